/* File: iasl_pkg.sv */
/*
  iasl_pkg: register indexes, field positions, reset values and link
  framing constants for the inter-amplifier share link controller.
  Assumes a 32-bit classic Wishbone bus in which each register takes one
  word, so the byte address is four times the register index.
*/
package iasl_pkg;
  // bus shape
  localparam int IASL_ADR_W = 16;
  localparam int IASL_DAT_W = 32;
  localparam int IASL_IDX_W = 14;

  // register indexes (byte address = 4 * index)
  localparam logic [IASL_IDX_W-1:0] IASL_IDX_RX_LOW = 14'h2070;
  localparam logic [IASL_IDX_W-1:0] IASL_IDX_RX_HIGH = 14'h2071;
  localparam logic [IASL_IDX_W-1:0] IASL_IDX_TX_CTRL = 14'h2072;
  localparam logic [IASL_IDX_W-1:0] IASL_IDX_ENABLES = 14'h207f;
  localparam logic [IASL_IDX_W-1:0] IASL_IDX_STATUS = 14'h2081;

  // reset values and writable bit masks
  localparam logic [7:0] IASL_RST_RX = 8'h00;
  localparam logic [7:0] IASL_RST_TX_CTRL = 8'h00;
  localparam logic [7:0] IASL_RST_ENABLES = 8'h00;
  localparam logic [7:0] IASL_MASK_TX_CTRL = 8'h6f;
  localparam logic [7:0] IASL_MASK_ENABLES = 8'h07;

  // link_tx_control fields
  localparam int IASL_TXC_ALT_BIT = 6;
  localparam int IASL_TXC_SEL_BIT = 5;
  localparam int IASL_TXC_DEST_LSB = 0;
  localparam int IASL_TXC_DEST_W = 4;

  // link_enables fields
  localparam int IASL_EN_ROUTE_BIT = 2;
  localparam int IASL_EN_LINK_BIT = 1;
  localparam int IASL_EN_TX_BIT = 0;

  // status fields
  localparam int IASL_ST_LINK_BIT = 0;
  localparam int IASL_ST_OVF_BIT = 1;
  localparam int IASL_ST_TX_BIT = 2;
  localparam int IASL_ST_SLOT_LSB = 4;

  // audio word width codes and last bit index of a slot
  localparam logic [1:0] IASL_WW_16 = 2'h0;
  localparam logic [1:0] IASL_WW_24 = 2'h1;
  localparam logic [4:0] IASL_LAST_16 = 5'h0f;
  localparam logic [4:0] IASL_LAST_24 = 5'h17;
  localparam logic [4:0] IASL_LAST_32 = 5'h1f;
  localparam logic [31:0] IASL_MASK_W16 = 32'h0000ffff;
  localparam logic [31:0] IASL_MASK_W24 = 32'h00ffffff;

  // link framing
  localparam int IASL_CHANNELS = 16;
  localparam logic [3:0] IASL_LAST_SLOT = 4'hf;
  localparam int IASL_PAY_W = 15;
endpackage

/* File: iasl_pair_buffer.sv */
/*
  iasl_pair_buffer: two-entry valid/ready buffer in flip-flops.
  Assumes both sides run on clk; in_ready falls only when both entries hold data.
*/
`timescale 1ns/100ps
module iasl_pair_buffer #(
  parameter int WIDTH = 36
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] entry;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } iasl_buf_state_t;

  iasl_buf_state_t st_reg;
  iasl_buf_state_t st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.count != 2'h2);
  assign out_valid = (st_reg.count != 2'h0);
  assign out_data = st_reg.entry[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.entry[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = ~st_reg.wr_ptr;
    end
    if (pop) begin
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 2'h1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  chk_buf_no_overfill: assert property (@(posedge clk) disable iff (reset)
    st_reg.count <= 2'h2) else $error("buffer holds more than two entries");
endmodule

/* File: iasl_link_ctrl.sv */
/*
  iasl_link_ctrl: register bank and slot engine of the shared inter-amplifier
  link. Holds receive accept masks, transmit channel/payload control and link
  enables, drives own-slot data on the link pin or the serial data output and
  hands accepted words to a two-entry buffer.
  Assumes audio bit clock, frame sync and link pin arrive asynchronously; the
  payload inputs, word width and audio output enable come from logic on clk.
*/
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// [RL1] one accept bit per channel 8..15, bit 7 is channel 15, bit 0 channel 8
// [RL2] a companion register holds accept bits for channels 0..7
// [RL3] 16-bit words, no alternating: select 0 sends headroom, 1 thermal, both with brownout
// [RL4] alternate mode in 16-bit words swaps headroom and thermal each own-slot send
// [RL5] 24- and 32-bit words ignore alternate and select bits
// [RL6] four-bit channel select picks which of 16 slots carries own data
// [RL7] routing bit sends link data on serial data output instead of link pin; here the link pin still drives while the transmitter bit is set
// [RL8] master enable off: no send, no receive, no acceptance of link data
// [RL9] link pin transmitter on or off, independent of receive acceptance
// [RL10] routed data appears only while the audio serial output is enabled
// [RL11] every device on the link uses a distinct transmit channel
module iasl_link_ctrl
  import iasl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [iasl_pkg::IASL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [iasl_pkg::IASL_DAT_W-1:0] wb_dat_i,
  output logic [iasl_pkg::IASL_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // audio serial interface timing
  input wire logic audio_bclk_pin,
  input wire logic audio_fsync_pin,
  input wire logic [1:0] audio_word_width,
  input wire logic audio_out_enable,
  // link and serial data output pins
  input wire logic link_pin_in,
  output logic link_pin_out,
  output logic link_pin_oe,
  output logic serial_out_data,
  output logic serial_out_oe,
  // local payload sources
  input wire logic [iasl_pkg::IASL_PAY_W-1:0] headroom_tracking,
  input wire logic [iasl_pkg::IASL_PAY_W-1:0] thermal_foldback,
  input wire logic brownout_guard,
  // accepted receive words
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [3:0] rx_chan,
  output logic [31:0] rx_data
);
  import iasl_pkg::*;

  typedef struct packed {
    logic [2:0] bclk_sync;
    logic bclk_lvl;
    logic [2:0] fs_sync;
    logic fs_lvl;
    logic fs_prev;
    logic [2:0] din_sync;
    logic din_lvl;
    logic [7:0] rx_low;
    logic [7:0] rx_high;
    logic [7:0] tx_ctrl;
    logic [7:0] enables;
    logic ovf;
    logic in_frame;
    logic [4:0] bit_cnt;
    logic [3:0] slot;
    logic [31:0] rx_shift;
    logic [31:0] tx_shift;
    logic alt_phase;
    logic own_active;
    logic pin_out;
    logic pin_oe;
    logic ser_out;
    logic ser_oe;
    logic ack;
    logic [31:0] rdata;
  } iasl_state_t;

  iasl_state_t st_reg;
  iasl_state_t st_next;

  logic bclk_rise;
  logic bclk_fall;
  logic frame_start;
  logic [4:0] last_bit;
  logic [31:0] width_mask;
  logic wide_word;
  logic master_en;
  logic [3:0] dest;
  logic [15:0] accept;
  logic use_thermal;
  logic [31:0] tx_word;
  logic own_load;
  logic push_try;
  logic push_ok;
  logic [35:0] push_data;
  logic buf_in_ready;
  logic [35:0] buf_out;
  logic bus_req;
  logic bus_wr;
  logic [IASL_IDX_W-1:0] idx;
  logic [31:0] rd_mux;
  logic [7:0] status;

  // filtered edges: only stages two and three are inspected
  assign bclk_rise = st_reg.bclk_sync[1] && st_reg.bclk_sync[2] && !st_reg.bclk_lvl;
  assign bclk_fall = !st_reg.bclk_sync[1] && !st_reg.bclk_sync[2] && st_reg.bclk_lvl;
  assign frame_start = st_reg.fs_lvl && !st_reg.fs_prev;

  assign wide_word = (audio_word_width != IASL_WW_16);
  assign master_en = st_reg.enables[IASL_EN_LINK_BIT];
  assign dest = st_reg.tx_ctrl[IASL_TXC_DEST_LSB +: IASL_TXC_DEST_W];
  assign accept = {st_reg.rx_high, st_reg.rx_low}; // RL1 RL2

  always_comb begin
    unique case (audio_word_width)
      IASL_WW_16: begin
        last_bit = IASL_LAST_16;
        width_mask = IASL_MASK_W16;
      end
      IASL_WW_24: begin
        last_bit = IASL_LAST_24;
        width_mask = IASL_MASK_W24;
      end
      default: begin
        last_bit = IASL_LAST_32;
        width_mask = '1;
      end
    endcase
  end

  // payload choice; word is MSB aligned so shorter slots send its top bits
  always_comb begin
    if (st_reg.tx_ctrl[IASL_TXC_ALT_BIT]) begin
      use_thermal = st_reg.alt_phase; // RL4
    end else begin
      use_thermal = st_reg.tx_ctrl[IASL_TXC_SEL_BIT]; // RL3
    end
    if (wide_word) begin
      tx_word = {headroom_tracking, thermal_foldback, brownout_guard, 1'b0}; // RL5
    end else if (use_thermal) begin
      tx_word = {thermal_foldback, brownout_guard, 16'h0000}; // RL3
    end else begin
      tx_word = {headroom_tracking, brownout_guard, 16'h0000}; // RL3
    end
  end

  // bus decode: ack one cycle after request, dropped the cycle after
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr = bus_req && wb_we_i && st_reg.ack && wb_sel_i[0];
  assign idx = wb_adr_i[IASL_ADR_W-1:2];
  assign status = {st_reg.slot, 1'b0, st_reg.own_active, st_reg.ovf, master_en};

  always_comb begin
    unique case (idx)
      IASL_IDX_RX_LOW: rd_mux = {24'h000000, st_reg.rx_low};
      IASL_IDX_RX_HIGH: rd_mux = {24'h000000, st_reg.rx_high};
      IASL_IDX_TX_CTRL: rd_mux = {24'h000000, st_reg.tx_ctrl};
      IASL_IDX_ENABLES: rd_mux = {24'h000000, st_reg.enables};
      IASL_IDX_STATUS: rd_mux = {24'h000000, status};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign own_load = bclk_rise && st_next.own_active && (st_next.bit_cnt == 5'h00);
  assign push_try = bclk_fall && st_reg.in_frame && (st_reg.bit_cnt == last_bit)
    && master_en && accept[st_reg.slot]; // RL1 RL2 RL8
  assign push_ok = push_try && buf_in_ready;
  assign push_data = {st_reg.slot, {st_reg.rx_shift[30:0], st_reg.din_lvl} & width_mask};

  always_comb begin
    st_next = st_reg;
    // three-stage synchronisers with agreement filter
    st_next.bclk_sync = {st_reg.bclk_sync[1:0], audio_bclk_pin};
    st_next.fs_sync = {st_reg.fs_sync[1:0], audio_fsync_pin};
    st_next.din_sync = {st_reg.din_sync[1:0], link_pin_in};
    if (st_reg.bclk_sync[1] == st_reg.bclk_sync[2]) begin
      st_next.bclk_lvl = st_reg.bclk_sync[2];
    end
    if (st_reg.fs_sync[1] == st_reg.fs_sync[2]) begin
      st_next.fs_lvl = st_reg.fs_sync[2];
    end
    if (st_reg.din_sync[1] == st_reg.din_sync[2]) begin
      st_next.din_lvl = st_reg.din_sync[2];
    end

    // bit clock rise: advance slot position and launch own bits
    if (bclk_rise) begin
      st_next.fs_prev = st_reg.fs_lvl;
      if (frame_start) begin
        st_next.in_frame = 1'b1;
        st_next.bit_cnt = 5'h00;
        st_next.slot = 4'h0;
      end else if (st_reg.bit_cnt == last_bit) begin
        st_next.bit_cnt = 5'h00;
        if (st_reg.slot == IASL_LAST_SLOT) begin
          st_next.in_frame = 1'b0;
        end else begin
          st_next.slot = st_reg.slot + 4'h1;
        end
      end else begin
        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      end
      st_next.own_active = st_next.in_frame && master_en && (st_next.slot == dest); // RL6 RL8 RL11
      if (st_next.own_active && (st_next.bit_cnt == 5'h00)) begin
        st_next.tx_shift = tx_word;
        st_next.pin_out = tx_word[31];
        if (st_reg.tx_ctrl[IASL_TXC_ALT_BIT] && !wide_word) begin
          st_next.alt_phase = ~st_reg.alt_phase; // RL4
        end
      end else if (st_next.own_active) begin
        st_next.tx_shift = {st_reg.tx_shift[30:0], 1'b0};
        st_next.pin_out = st_reg.tx_shift[30];
      end else begin
        st_next.pin_out = 1'b0;
      end
      st_next.pin_oe = st_next.own_active && st_reg.enables[IASL_EN_TX_BIT]; // RL9
      st_next.ser_oe = st_next.own_active && st_reg.enables[IASL_EN_ROUTE_BIT]
        && audio_out_enable; // RL7 RL10
      st_next.ser_out = st_next.pin_out;
    end

    // bit clock fall: peers' bits are sampled here
    if (bclk_fall && st_reg.in_frame) begin
      st_next.rx_shift = {st_reg.rx_shift[30:0], st_reg.din_lvl};
    end

    // register bank; hardware set of overflow wins over clear
    st_next.ack = bus_req && !st_reg.ack;
    if (!st_reg.ack) begin
      st_next.rdata = rd_mux;
    end
    if (bus_wr) begin
      unique case (idx)
        IASL_IDX_RX_LOW: st_next.rx_low = wb_dat_i[7:0];
        IASL_IDX_RX_HIGH: st_next.rx_high = wb_dat_i[7:0];
        IASL_IDX_TX_CTRL: st_next.tx_ctrl = wb_dat_i[7:0] & IASL_MASK_TX_CTRL;
        IASL_IDX_ENABLES: st_next.enables = wb_dat_i[7:0] & IASL_MASK_ENABLES;
        IASL_IDX_STATUS: begin
          if (wb_dat_i[IASL_ST_OVF_BIT]) begin
            st_next.ovf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // stop driving at once when enables drop, using the value being written
    if (!st_next.enables[IASL_EN_LINK_BIT]) begin
      st_next.own_active = 1'b0; // RL8
      st_next.pin_oe = 1'b0;
      st_next.ser_oe = 1'b0;
    end
    if (!st_next.enables[IASL_EN_TX_BIT]) begin
      st_next.pin_oe = 1'b0;
    end
    if (!st_next.enables[IASL_EN_ROUTE_BIT] || !audio_out_enable) begin
      st_next.ser_oe = 1'b0;
    end
    if (push_try && !buf_in_ready) begin
      st_next.ovf = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.rx_low <= IASL_RST_RX;
      st_reg.rx_high <= IASL_RST_RX;
      st_reg.tx_ctrl <= IASL_RST_TX_CTRL;
      st_reg.enables <= IASL_RST_ENABLES;
    end else begin
      st_reg <= st_next;
    end
  end

  iasl_pair_buffer #(
    .WIDTH(36)
  ) u_rx_buf (
    .clk(clk),
    .reset(reset),
    .in_valid(push_try),
    .in_ready(buf_in_ready),
    .in_data(push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(buf_out)
  );

  assign rx_chan = buf_out[35:32];
  assign rx_data = buf_out[31:0];
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdata;
  assign link_pin_out = st_reg.pin_out;
  assign link_pin_oe = st_reg.pin_oe;
  assign serial_out_data = st_reg.ser_out;
  assign serial_out_oe = st_reg.ser_oe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_bus_ack;
    bus_req ##1 wb_ack_o;
  endsequence

  chk_ack_single_pulse: assert property (s_bus_ack |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_pin_oe_gated: assert property (link_pin_oe |-> master_en // RL9
    && st_reg.enables[IASL_EN_TX_BIT]) else $error("link pin driven while disabled");
  chk_pin_own_slot: assert property (link_pin_oe |-> st_reg.slot == dest // RL6
    && st_reg.in_frame) else $error("link pin driven outside own slot");
  chk_route_gated: assert property (serial_out_oe |-> audio_out_enable // RL10
    && st_reg.enables[IASL_EN_ROUTE_BIT]) else $error("serial output routed while disabled");
  chk_master_gate: assert property (!master_en |=> !link_pin_oe && !serial_out_oe // RL8
    && !st_reg.own_active) else $error("link active with master enable off");
  chk_rx_accept_bit: assert property (push_ok |-> accept[st_reg.slot] // RL1
    && master_en) else $error("word accepted from disabled channel");
  chk_rx_lands: assert property (push_ok && !rx_valid |=> rx_valid // RL2
    && rx_chan == $past(st_reg.slot)) else $error("accepted word not presented");
  chk_fixed_payload: assert property (own_load && !wide_word // RL3
    && !st_reg.tx_ctrl[IASL_TXC_ALT_BIT] |=> st_reg.tx_shift[16] == $past(brownout_guard)
    && st_reg.tx_shift[31:17] == (st_reg.tx_ctrl[IASL_TXC_SEL_BIT]
    ? $past(thermal_foldback) : $past(headroom_tracking)))
    else $error("fixed payload mismatch");
  chk_alt_toggle: assert property (own_load && !wide_word // RL4
    && st_reg.tx_ctrl[IASL_TXC_ALT_BIT] |=> st_reg.alt_phase != $past(st_reg.alt_phase))
    else $error("alternate phase did not swap");
  chk_wide_ignore: assert property (own_load && wide_word // RL5
    |=> st_reg.tx_shift[31:17] == $past(headroom_tracking)
    && st_reg.alt_phase == $past(st_reg.alt_phase)) else $error("wide word used select bits");
endmodule

/* File: iasl_peer_model.sv */
/*
  iasl_peer_model: peer amplifier on the shared link. Makes the bit clock and
  frame sync, sends one word in its own slot and records one slot of the wire.
  Assumes it runs on the bench clock; the bit clock is clk divided by 12.
*/
`timescale 1ns/100ps
module iasl_peer_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench control
  input wire logic [5:0] word_bits,
  input wire logic peer_on,
  input wire logic [3:0] peer_chan,
  input wire logic [31:0] peer_word,
  input wire logic [3:0] cap_chan,
  input wire logic wire_in,
  // far-side pins
  output logic bclk,
  output logic fsync,
  output logic peer_drive,
  output logic peer_bit,
  // observations
  output logic [31:0] cap_word,
  output int frame_cnt
);
  int div;
  int pos;
  int npos;
  int tot;
  logic drv;
  logic [31:0] sh;
  always_comb tot = 16 * word_bits + 4;
  always @(posedge clk) begin
    if (reset) begin
      bclk <= 1'b0;
      fsync <= 1'b0;
      peer_drive <= 1'b0;
      peer_bit <= 1'b0;
      div <= 0;
      pos <= tot - 2;
      frame_cnt <= 0;
      cap_word <= 32'h0;
    end else if (div < 5) begin
      div <= div + 1;
    end else begin
      div <= 0;
      bclk <= ~bclk;
      if (bclk) begin
        // sync straddles the rise that opens slot 0
        fsync <= (pos == tot - 1);
      end else begin
        // sample the bit that stood for the whole past period
        if (pos < tot - 4 && pos / word_bits == cap_chan) begin
          sh = (pos % word_bits == 0) ? {31'h0, wire_in} : {sh[30:0], wire_in};
          if (pos % word_bits == word_bits - 1) cap_word <= sh;
        end
        npos = (pos == tot - 1) ? 0 : pos + 1;
        pos <= npos;
        if (npos == 0) frame_cnt <= frame_cnt + 1;
        drv = peer_on && npos < tot - 4 && npos / word_bits == peer_chan;
        peer_drive <= drv;
        // released wire toggles so no stale level passes for data
        peer_bit <= drv ? peer_word[word_bits - 1 - npos % word_bits] : ~peer_bit;
      end
    end
  end
endmodule

/* File: tb.sv */
/*
  tb: self-checking bench for iasl_link_ctrl with a peer model on the link.
  Assumes a 200 MHz clock and a 16-cycle synchronous reset.
*/
`timescale 1ns/100ps
module tb;
  import iasl_pkg::*;
  logic clk, reset, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [15:0] wb_adr;
  logic [3:0] wb_sel, rx_chan, peer_chan, cap_chan;
  logic [31:0] wb_wdat, wb_rdat, rx_data, peer_word, cap_word, q;
  logic [1:0] word_width;
  logic aud_oe, brown, rx_ready, rx_valid, peer_on, cap_ser;
  logic [14:0] head, therm;
  logic pin_out, pin_oe, ser_data, ser_oe, bclk, fsync, peer_drive, peer_bit;
  logic [5:0] word_bits;
  int frame_cnt, miscompares, samples_checked, pin_n, ser_n, p0;
  wire link_wire = peer_drive ? peer_bit : (pin_oe ? pin_out : peer_bit);

  iasl_link_ctrl dut_u (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .audio_bclk_pin(bclk), .audio_fsync_pin(fsync),
    .audio_word_width(word_width), .audio_out_enable(aud_oe), .link_pin_in(link_wire),
    .link_pin_out(pin_out), .link_pin_oe(pin_oe), .serial_out_data(ser_data),
    .serial_out_oe(ser_oe), .headroom_tracking(head), .thermal_foldback(therm),
    .brownout_guard(brown), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_chan(rx_chan),
    .rx_data(rx_data));
  iasl_peer_model peer_u (.clk(clk), .reset(reset), .word_bits(word_bits), .peer_on(peer_on),
    .peer_chan(peer_chan), .peer_word(peer_word), .cap_chan(cap_chan),
    .wire_in(cap_ser ? ser_data : link_wire), .bclk(bclk), .fsync(fsync),
    .peer_drive(peer_drive), .peer_bit(peer_bit), .cap_word(cap_word), .frame_cnt(frame_cnt));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    pin_n <= pin_n + int'(pin_oe === 1'b1);
    ser_n <= ser_n + int'(ser_oe === 1'b1);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic we, input logic [13:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_sel <= 4'h1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rdat;
    if (n >= 50) begin
      check("bus ack", 32'h0, 32'h1);
      complete_run();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic frames(input int n);
    int f0;
    int k;
    f0 = frame_cnt;
    k = 0;
    while (frame_cnt < f0 + n && k < 8000 * n) begin
      @(posedge clk);
      k++;
    end
    if (frame_cnt < f0 + n) begin
      check("frame wait", 32'h0, 32'h1);
      complete_run();
    end
  endtask
  task automatic take(input logic [3:0] ch);
    check("rx valid", {31'h0, rx_valid}, 32'h1);
    check("rx chan", {28'h0, rx_chan}, {28'h0, ch});
    check("rx data", rx_data, {16'h0, peer_word[15:0]});
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_regs();
    logic [13:0] idx [4];
    logic [7:0] msk [4];
    idx = '{IASL_IDX_RX_LOW, IASL_IDX_RX_HIGH, IASL_IDX_TX_CTRL, IASL_IDX_ENABLES};
    msk = '{8'hff, 8'hff, IASL_MASK_TX_CTRL, IASL_MASK_ENABLES};
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, idx[i], 8'h00);
      check("reg reset", q, 32'h0);
      bus(1'b1, idx[i], 8'hff);
      bus(1'b0, idx[i], 8'h00);
      check("reg rw", q, {24'h0, msk[i]});
      bus(1'b1, idx[i], 8'h00);
    end
    bus(1'b1, 14'h2090, 8'h5a);
    bus(1'b0, 14'h2090, 8'h00);
    check("unmapped", q, 32'h0);
  endtask
  task automatic t_tx16();
    logic [31:0] w1;
    bus(1'b1, IASL_IDX_ENABLES, 8'h03);
    for (int i = 0; i < 2; i++) begin
      cap_chan <= i ? 4'hf : 4'h5;
      bus(1'b1, IASL_IDX_TX_CTRL, i ? 8'h2f : 8'h05);
      frames(1);
      check("tx16 word", cap_word, {16'h0, i ? therm : head, brown});
    end
    bus(1'b1, IASL_IDX_TX_CTRL, 8'h4f);
    frames(1);
    w1 = cap_word;
    frames(1);
    check("alternate", {31'h0, w1[15:0] != cap_word[15:0] && (w1[15:0] == {head, brown}
      || cap_word[15:0] == {head, brown})}, 32'h1);
    bus(1'b1, IASL_IDX_TX_CTRL, 8'h65);
    cap_chan <= 4'h5;
    for (int w = 24; w <= 32; w += 8) begin
      word_width <= (w == 24) ? IASL_WW_24 : 2'h2;
      word_bits <= w[5:0];
      frames(1);
      check("wide word", cap_word, {head, therm, brown, 1'b0} >> (32 - w));
    end
    word_width <= IASL_WW_16;
    word_bits <= 6'd16;
  endtask
  task automatic t_rx();
    bus(1'b1, IASL_IDX_ENABLES, 8'h02);
    bus(1'b1, IASL_IDX_RX_HIGH, 8'h02);
    peer_chan <= 4'h9;
    peer_on <= 1'b1;
    p0 = pin_n;
    frames(1);
    check("pin off", pin_n - p0, 32'h0);
    take(4'h9);
    bus(1'b1, IASL_IDX_RX_HIGH, 8'h00);
    frames(1);
    check("ch9 ignored", {31'h0, rx_valid}, 32'h0);
    bus(1'b1, IASL_IDX_RX_LOW, 8'h08);
    peer_chan <= 4'h3;
    frames(1);
    take(4'h3);
    bus(1'b1, IASL_IDX_ENABLES, 8'h01);
    p0 = pin_n;
    frames(1);
    check("off rx", {31'h0, rx_valid}, 32'h0);
    check("off tx", pin_n - p0, 32'h0);
    bus(1'b1, IASL_IDX_ENABLES, 8'h02);
    frames(3);
    bus(1'b0, IASL_IDX_STATUS, 8'h00);
    check("overflow", q & 32'h3, 32'h3);
    take(4'h3);
    take(4'h3);
    check("drained", {31'h0, rx_valid}, 32'h0);
    bus(1'b1, IASL_IDX_STATUS, 8'h02);
    bus(1'b0, IASL_IDX_STATUS, 8'h00);
    check("ovf clear", q & 32'h2, 32'h0);
  endtask
  task automatic t_route();
    peer_on <= 1'b0;
    cap_ser <= 1'b1;
    aud_oe <= 1'b1;
    bus(1'b1, IASL_IDX_ENABLES, 8'h06);
    p0 = ser_n;
    frames(1);
    check("routed word", cap_word, {16'h0, head, brown});
    check("routed oe cycles", ser_n - p0, 32'hc0);
    aud_oe <= 1'b0;
    p0 = ser_n;
    frames(1);
    check("routed off", ser_n - p0, 32'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #450000;
    miscompares++;
    complete_run();
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, aud_oe, rx_ready, peer_on, cap_ser} = 7'h0;
    {wb_adr, wb_sel, wb_wdat} = '0;
    miscompares = 0;
    samples_checked = 0;
    pin_n = 0;
    ser_n = 0;
    reset = 1'b1;
    word_width = IASL_WW_16;
    word_bits = 6'd16;
    head = 15'h2a5c;
    therm = 15'h1337;
    brown = 1'b1;
    peer_chan = 4'h9;
    cap_chan = 4'h5;
    peer_word = 32'h0000c3a5;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    frames(1);
    t_tx16();
    t_rx();
    t_route();
    complete_run();
  end
endmodule
